// >>> rtl/spc_consts.svh
// Constants shared by the command parser files
`ifndef SPC_CONSTS_SVH
`define SPC_CONSTS_SVH

// ****************************************************************
// Character codes
// ****************************************************************
`define SPC_CH_COLON   8'h3A
`define SPC_CH_SEMI    8'h3B
`define SPC_CH_SPACE   8'h20
`define SPC_CH_COMMA   8'h2C
`define SPC_CH_QMARK   8'h3F
`define SPC_CH_STAR    8'h2A
`define SPC_CH_LF      8'h0A
`define SPC_CH_CR      8'h0D
`define SPC_CH_MINUS   8'h2D
`define SPC_CH_0       8'h30
`define SPC_CH_9       8'h39
`define SPC_CH_UP_A    8'h41
`define SPC_CH_UP_Z    8'h5A
`define SPC_CH_LO_A    8'h61
`define SPC_CH_LO_Z    8'h7A
`define SPC_CASE_MASK  8'hDF

// ****************************************************************
// Keyword buffer and lengths
// ****************************************************************
`define SPC_KW_BITS     96
`define SPC_KW_LEN_MAX  4'hC
`define SPC_CMN_LET_MAX 4'h4
`define SPC_CMN_LEN_MIN 4'h4
`define SPC_CMN_LEN_MAX 4'h5
`define SPC_RADIX       16'h000A

// ****************************************************************
// Command tree node codes
// ****************************************************************
`define SPC_NODE_W      4
`define SPC_NODE_COUNT  10
`define SPC_N_ROOT      4'h0
`define SPC_N_CAL       4'h1
`define SPC_N_RESTORE   4'h2
`define SPC_N_DEFAULT   4'h3
`define SPC_N_VOLT      4'h4
`define SPC_N_CURR      4'h5
`define SPC_N_SYST      4'h6
`define SPC_N_ERR       4'h7
`define SPC_N_NEXT      4'h8
`define SPC_N_OUTP      4'h9
`define SPC_N_STATE     4'hA

// ****************************************************************
// Parameter words and error codes (two's complement)
// ****************************************************************
`define SPC_WORD_MIN    32'h004D494E
`define SPC_WORD_MAX    32'h004D4158
`define SPC_WORD_DEF    32'h00444546
`define SPC_ERR_SYNTAX  16'hFF9A
`define SPC_ERR_UNDEF   16'hFF8F
`define SPC_ERR_SUFFIX  16'hFF7D

// ****************************************************************
// Calibration defaults
// ****************************************************************
`define SPC_CAL_GAIN_UNITY  16'h2710
`define SPC_CAL_OFFSET_ZERO 16'h0000

`endif

// >>> rtl/spc_pkg.sv
// Types shared by the command parser files
`include "spc_consts.svh"
package spc_pkg;
	typedef logic [`SPC_NODE_W-1:0] spc_node_t;
	typedef enum logic [1:0] {SPC_ST_HDR, SPC_ST_PRM, SPC_ST_SKIP} spc_state_t;
	typedef enum logic [2:0] {SPC_PK_NUM, SPC_PK_MIN, SPC_PK_MAX, SPC_PK_DEF, SPC_PK_WORD} spc_pkind_t;
	typedef struct packed {
		spc_node_t                parent;
		logic [`SPC_KW_BITS-1:0]  text;
		logic [3:0]               llen;
		logic [3:0]               slen;
		spc_node_t                dflt;
		logic                     param;
	} spc_kw_t;
endpackage

// >>> rtl/spc_kw_match.sv
// Keyword table lookup against the collected header keyword
`include "spc_consts.svh"
module spc_kw_match (
	input  wire logic [`SPC_KW_BITS-1:0] kw_i,
	input  wire logic [3:0]              len_i,
	input  wire spc_pkg::spc_node_t      parent_i,
	input  wire spc_pkg::spc_node_t      attr_i,
	output logic                         hit_o,
	output spc_pkg::spc_node_t           node_o,
	output spc_pkg::spc_node_t           dflt_o,
	output logic                         param_o
);
	import spc_pkg::*;

	// ****************************************************************
	// Keyword table: parent, long form, lengths, default child
	// ****************************************************************
	function automatic spc_kw_t kw_entry(input spc_node_t n);
		case (n)
			`SPC_N_CAL:     kw_entry = '{`SPC_N_ROOT, "CALIBRATION", 4'hB, 4'h3, `SPC_N_ROOT, 1'b0};
			`SPC_N_RESTORE: kw_entry = '{`SPC_N_CAL, "RESTORE", 4'h7, 4'h4, `SPC_N_ROOT, 1'b0};
			`SPC_N_DEFAULT: kw_entry = '{`SPC_N_CAL, "DEFAULT", 4'h7, 4'h3, `SPC_N_ROOT, 1'b0};
			`SPC_N_VOLT:    kw_entry = '{`SPC_N_ROOT, "VOLTAGE", 4'h7, 4'h4, `SPC_N_ROOT, 1'b1};
			`SPC_N_CURR:    kw_entry = '{`SPC_N_ROOT, "CURRENT", 4'h7, 4'h4, `SPC_N_ROOT, 1'b1};
			`SPC_N_SYST:    kw_entry = '{`SPC_N_ROOT, "SYSTEM", 4'h6, 4'h4, `SPC_N_ROOT, 1'b0};
			`SPC_N_ERR:     kw_entry = '{`SPC_N_SYST, "ERROR", 4'h5, 4'h3, `SPC_N_NEXT, 1'b0};
			`SPC_N_NEXT:    kw_entry = '{`SPC_N_ERR, "NEXT", 4'h4, 4'h4, `SPC_N_ROOT, 1'b0};
			`SPC_N_OUTP:    kw_entry = '{`SPC_N_ROOT, "OUTPUT", 4'h6, 4'h4, `SPC_N_STATE, 1'b0};
			`SPC_N_STATE:   kw_entry = '{`SPC_N_OUTP, "STATE", 4'h5, 4'h4, `SPC_N_ROOT, 1'b1};
			default:        kw_entry = '0;
		endcase
	endfunction

	logic [`SPC_NODE_COUNT:1] hit_v;
	spc_kw_t                  attr_e;

	// ****************************************************************
	// Per entry compare: exact long form or exact short form only
	// ****************************************************************
	for (genvar g = 1; g <= `SPC_NODE_COUNT; g++) begin : g_kw
		spc_kw_t e;
		assign e = kw_entry(spc_node_t'(g));
		assign hit_v[g] = (e.parent == parent_i) && ((kw_i == e.text) ||
			((len_i == e.slen) && (kw_i == (e.text >> {e.llen - e.slen, 3'b000}))));
	end

	// First hit wins
	always_comb begin
		hit_o  = 1'b0;
		node_o = `SPC_N_ROOT;
		for (int i = 1; i <= `SPC_NODE_COUNT; i++) begin
			if (hit_v[i] && !hit_o) begin
				hit_o  = 1'b1;
				node_o = spc_node_t'(i);
			end
		end
	end

	// Attributes of the node being finished
	assign attr_e  = kw_entry(attr_i);
	assign dflt_o  = attr_e.dflt;
	assign param_o = attr_e.param;
endmodule

// >>> rtl/spc_cal_store.sv
// Calibration coefficient store with restore, default and boot fallback
`include "spc_consts.svh"
module spc_cal_store #(
	parameter int                            N_COEF    = 4,
	parameter int                            COEF_W    = 16,
	parameter logic [2*N_COEF*COEF_W-1:0]    P_FACTORY = {N_COEF{`SPC_CAL_OFFSET_ZERO, `SPC_CAL_GAIN_UNITY}}
) (
	input  wire logic                        sys_clk_i,
	input  wire logic                        rst_i,
	input  wire logic                        restore_i,
	input  wire logic                        default_i,
	input  wire logic                        boot_done_i,
	input  wire logic                        boot_csum_ok_i,
	input  wire logic [2*N_COEF*COEF_W-1:0]  boot_coef_i,
	output logic      [2*N_COEF*COEF_W-1:0]  coef_o,
	output logic                             flash_fail_message_o,
	output logic                             opt_default_o
);
	import spc_pkg::*;

	// Each pair is {offset, gain}; unity gain and zero offset
	localparam logic [COEF_W-1:0]            GAIN_ONE = COEF_W'(`SPC_CAL_GAIN_UNITY);
	localparam logic [COEF_W-1:0]            OFFS_ZERO = COEF_W'(`SPC_CAL_OFFSET_ZERO);
	localparam logic [2*N_COEF*COEF_W-1:0]   DEF_COEF = {N_COEF{OFFS_ZERO, GAIN_ONE}};

	// ****************************************************************
	// Coefficient register
	// ****************************************************************
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			coef_o <= DEF_COEF;
		end else if (boot_done_i) begin
			coef_o <= boot_csum_ok_i ? boot_coef_i : DEF_COEF;
		end else if (default_i) begin
			coef_o <= DEF_COEF;
		end else if (restore_i) begin
			coef_o <= P_FACTORY;
		end
	end

	// Flash failure indication, held until reset
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			flash_fail_message_o <= 1'b0;
			opt_default_o        <= 1'b0;
		end else if (boot_done_i && !boot_csum_ok_i) begin
			flash_fail_message_o <= 1'b1;
			opt_default_o        <= 1'b1;
		end
	end
endmodule

// >>> rtl/spc_cmd_parser.sv
// Command parser top: header resolution, parameters, errors, calibration
//
// Contract
// - Restore command loads the stored factory calibration coefficients.
// - Default command sets all coefficients to unity gain, zero offset.
// - Bad stored checksum: show flash failure, boot default options and calibration.
// - Only default units; any unit suffix pushes an error.
// - Keyword matching ignores letter case.
// - Keyword must equal its full or 3/4-letter short form exactly.
// - Colon separates keyword levels; space separates header from parameters.
// - Commas split parameters, delivered in received order.
// - After semicolon, next command resolves relative to current subsystem path.
// - Semicolon then colon returns the path to root.
// - Omitted optional keyword or parameter acts as the default one; bare OUTP reports STATE with no default parameter.
// - MIN and MAX substitute the model minimum or maximum value.
// - Question mark queries the setting; with MIN/MAX the limit.
// - Line feed ends message, optional carriage return; executes, path to root.
// - Common commands start with asterisk, 4 or 5 characters long.
`include "spc_consts.svh"
module spc_cmd_parser #(
	parameter int                            N_COEF    = 4,
	parameter int                            COEF_W    = 16,
	parameter logic [15:0]                   P_MIN_VAL = 16'h0000,
	parameter logic [15:0]                   P_MAX_VAL = 16'h7FFF,
	parameter logic [2*N_COEF*COEF_W-1:0]    P_FACTORY = {N_COEF{`SPC_CAL_OFFSET_ZERO, `SPC_CAL_GAIN_UNITY}}
) (
	input  wire logic                        sys_clk_i,
	input  wire logic                        rst_i,
	input  wire logic                        rx_valid_i,
	input  wire logic [7:0]                  rx_char_i,
	input  wire logic                        boot_done_i,
	input  wire logic                        boot_csum_ok_i,
	input  wire logic [2*N_COEF*COEF_W-1:0]  boot_coef_i,
	output logic                             cmd_valid_o,
	output spc_pkg::spc_node_t               cmd_node_o,
	output logic                             cmd_query_o,
	output logic                             cmd_common_o,
	output logic [31:0]                      cmd_code_o,
	output logic                             prm_valid_o,
	output logic [3:0]                       prm_index_o,
	output spc_pkg::spc_pkind_t              prm_kind_o,
	output logic [15:0]                      prm_value_o,
	output logic                             err_push_o,
	output logic [15:0]                      err_code_o,
	output logic                             msg_exec_o,
	output logic [2*N_COEF*COEF_W-1:0]       cal_coef_o,
	output logic                             flash_fail_message_o,
	output logic                             opt_default_o
);
	import spc_pkg::*;

	// ****************************************************************
	// State
	// ****************************************************************
	spc_state_t                state_q;
	logic [`SPC_KW_BITS-1:0]   kw_q;
	logic [3:0]                kw_len_q;
	logic                      first_q;
	logic                      common_q;
	logic                      query_q;
	spc_node_t                 node_q;
	spc_node_t                 par_q;
	spc_node_t                 path_q;
	logic [3:0]                prm_idx_q;
	logic [15:0]               val_q;
	logic                      neg_q;
	logic                      dig_q;
	logic [31:0]               word_q;
	logic                      cal_rest_q;
	logic                      cal_def_q;

	logic [7:0]                up_c;
	logic                      is_let, is_dig, is_col, is_sp, is_qm, is_semi, is_lf, is_cr;
	logic                      is_comma, is_star, is_minus, hdr_sep, cmn_ok, restart;
	logic                      m_hit, a_param;
	spc_node_t                 m_node, a_dflt, cur_node, fin_node, leaf_par, path_d, out_node;
	logic                      a_let, a_star, a_root, a_res, a_qm, a_hdr2prm, a_cmd, a_def;
	logic                      a_prm, a_dig, a_neg, a_wl, a_err;
	logic [15:0]               err_c;
	spc_pkind_t                pk;
	logic [15:0]               pv;

	// ****************************************************************
	// Character classes
	// ****************************************************************
	// fold lower case to upper
	assign up_c     = (rx_char_i >= `SPC_CH_LO_A && rx_char_i <= `SPC_CH_LO_Z) ? (rx_char_i & `SPC_CASE_MASK)
	                                                                           : rx_char_i;
	assign is_let   = (up_c >= `SPC_CH_UP_A) && (up_c <= `SPC_CH_UP_Z);
	assign is_dig   = (up_c >= `SPC_CH_0) && (up_c <= `SPC_CH_9);
	assign is_col   = (up_c == `SPC_CH_COLON);
	assign is_sp    = (up_c == `SPC_CH_SPACE);
	assign is_qm    = (up_c == `SPC_CH_QMARK);
	assign is_semi  = (up_c == `SPC_CH_SEMI);
	assign is_lf    = (up_c == `SPC_CH_LF);
	assign is_cr    = (up_c == `SPC_CH_CR);
	assign is_comma = (up_c == `SPC_CH_COMMA);
	assign is_star  = (up_c == `SPC_CH_STAR);
	assign is_minus = (up_c == `SPC_CH_MINUS);
	assign hdr_sep  = is_col || is_sp || is_qm || is_semi || is_lf;
	// asterisk plus letters plus query mark is 4 or 5
	assign cmn_ok   = ((4'(kw_len_q + 4'h1 + {3'b000, query_q})) >= `SPC_CMN_LEN_MIN) &&
	                  ((4'(kw_len_q + 4'h1 + {3'b000, query_q})) <= `SPC_CMN_LEN_MAX);
	assign restart  = rx_valid_i && (is_semi || is_lf);

	// ****************************************************************
	// Keyword lookup
	// ****************************************************************
	spc_kw_match u_match (
		.kw_i     (kw_q),
		.len_i    (kw_len_q),
		.parent_i (node_q),
		.attr_i   (cur_node),
		.hit_o    (m_hit),
		.node_o   (m_node),
		.dflt_o   (a_dflt),
		.param_o  (a_param)
	);

	assign cur_node = (kw_len_q != 4'h0) ? m_node : node_q;
	// omitted optional keyword takes the default child
	assign fin_node = common_q ? `SPC_N_ROOT : ((a_dflt != `SPC_N_ROOT) ? a_dflt : cur_node);
	assign leaf_par = (state_q == SPC_ST_HDR && kw_len_q != 4'h0) ? node_q : par_q;
	// semicolon keeps the subsystem of the last command
	assign path_d   = is_lf ? `SPC_N_ROOT : ((a_cmd && !common_q) ? leaf_par : path_q);
	assign out_node = (state_q == SPC_ST_PRM) ? node_q : fin_node;

	// ****************************************************************
	// Per character decode into actions
	// ****************************************************************
	always_comb begin
		a_let = 1'b0; a_star = 1'b0; a_root = 1'b0; a_res = 1'b0; a_qm = 1'b0;
		a_hdr2prm = 1'b0; a_cmd = 1'b0; a_def = 1'b0; a_prm = 1'b0; a_dig = 1'b0;
		a_neg = 1'b0; a_wl = 1'b0; a_err = 1'b0; err_c = `SPC_ERR_SYNTAX;
		if (rx_valid_i && !is_cr) begin
			unique case (state_q)
				SPC_ST_HDR: begin
					if (common_q) begin
						if (is_let && !query_q && kw_len_q < `SPC_CMN_LET_MAX) a_let = 1'b1;
						else if (is_qm && !query_q) a_qm = 1'b1;
						else if ((is_sp || is_semi || is_lf) && cmn_ok) begin
							a_hdr2prm = is_sp;
							a_cmd     = !is_sp;
						end else begin
							a_err = 1'b1;
							err_c = `SPC_ERR_UNDEF;
						end
					end else if (is_let && !query_q) begin
						if (kw_len_q == `SPC_KW_LEN_MAX) begin
							a_err = 1'b1;
							err_c = `SPC_ERR_UNDEF;
						end else begin
							a_let = 1'b1;
						end
					end else if (is_sp && first_q) begin
						a_let = 1'b0;
					end else if (is_star && first_q) begin
						a_star = 1'b1;
					end else if (is_col && first_q) begin
						a_root = 1'b1;
					end else if (hdr_sep && kw_len_q != 4'h0 && !m_hit) begin
						a_err = 1'b1;
						err_c = `SPC_ERR_UNDEF;
					end else if (hdr_sep && kw_len_q != 4'h0) begin
						a_res     = 1'b1;
						a_qm      = is_qm;
						a_hdr2prm = is_sp;
						a_cmd     = is_semi || is_lf;
						a_def     = (is_semi || is_lf) && a_param;
					end else if ((is_sp || is_semi || is_lf) && query_q) begin
						// query with optional MIN or MAX
						a_hdr2prm = is_sp;
						a_cmd     = !is_sp;
					end else if (!((is_semi || is_lf) && first_q)) begin
						a_err = 1'b1;
					end
				end
				SPC_ST_PRM: begin
					if (is_dig && word_q == 32'h00000000) a_dig = 1'b1;
					else if (is_minus && !dig_q && word_q == 32'h00000000 && !neg_q) a_neg = 1'b1;
					else if (is_let && dig_q) begin
						a_err = 1'b1;
						err_c = `SPC_ERR_SUFFIX;
					end else if (is_let) a_wl = 1'b1;
					else if (is_sp) a_wl = 1'b0;
					else if (is_comma) a_prm = 1'b1;
					else if (is_semi || is_lf) begin
						a_prm = 1'b1;
						a_cmd = 1'b1;
					end else a_err = 1'b1;
				end
				SPC_ST_SKIP: begin
					a_err = 1'b0;
				end
			endcase
		end
	end

	// ****************************************************************
	// Parameter value
	// ****************************************************************
	always_comb begin
		pk = SPC_PK_NUM;
		pv = neg_q ? 16'(16'h0000 - val_q) : val_q;
		// MIN and MAX substitute model limits
		if (!dig_q && word_q == 32'h00000000) begin
			pk = SPC_PK_DEF;
			pv = 16'h0000;
		end else if (word_q == `SPC_WORD_MIN) begin
			pk = SPC_PK_MIN;
			pv = P_MIN_VAL;
		end else if (word_q == `SPC_WORD_MAX) begin
			pk = SPC_PK_MAX;
			pv = P_MAX_VAL;
		end else if (word_q == `SPC_WORD_DEF) begin
			pk = SPC_PK_DEF;
			pv = 16'h0000;
		end else if (word_q != 32'h00000000) begin
			pk = SPC_PK_WORD;
			pv = 16'h0000;
		end
	end

	// ****************************************************************
	// Header registers
	// ****************************************************************
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			state_q  <= SPC_ST_HDR;
			kw_q     <= '0;
			kw_len_q <= 4'h0;
			first_q  <= 1'b1;
			common_q <= 1'b0;
			query_q  <= 1'b0;
			node_q   <= `SPC_N_ROOT;
			par_q    <= `SPC_N_ROOT;
		end else if (restart) begin
			state_q  <= SPC_ST_HDR;
			kw_q     <= '0;
			kw_len_q <= 4'h0;
			first_q  <= 1'b1;
			common_q <= 1'b0;
			query_q  <= 1'b0;
			node_q   <= path_d;
			par_q    <= path_d;
		end else if (a_err) begin
			state_q <= SPC_ST_SKIP;
		end else begin
			if (a_let || a_star || a_root) first_q <= 1'b0;
			if (a_let) begin
				kw_q     <= {kw_q[`SPC_KW_BITS-9:0], up_c};
				kw_len_q <= 4'(kw_len_q + 4'h1);
			end
			if (a_star) common_q <= 1'b1;
			if (a_root) begin
				node_q <= `SPC_N_ROOT;
				par_q  <= `SPC_N_ROOT;
			end
			if (a_res) begin
				node_q   <= m_node;
				par_q    <= node_q;
				kw_q     <= '0;
				kw_len_q <= 4'h0;
			end
			if (a_qm) query_q <= 1'b1;
			if (a_hdr2prm) begin
				node_q  <= fin_node;
				state_q <= SPC_ST_PRM;
			end
		end
	end

	// Command path kept between commands of one message
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) path_q <= `SPC_N_ROOT;
		else if (restart) path_q <= path_d;
	end

	// ****************************************************************
	// Parameter registers
	// ****************************************************************
	always_ff @(posedge sys_clk_i) begin
		if (rst_i || restart || a_prm) begin
			val_q     <= 16'h0000;
			neg_q     <= 1'b0;
			dig_q     <= 1'b0;
			word_q    <= 32'h00000000;
			prm_idx_q <= (rst_i || restart) ? 4'h0 : 4'(prm_idx_q + 4'h1);
		end else begin
			if (a_dig) begin
				val_q <= 16'(val_q * `SPC_RADIX + {8'h00, 8'(up_c - `SPC_CH_0)});
				dig_q <= 1'b1;
			end
			if (a_neg) neg_q <= 1'b1;
			if (a_wl) word_q <= {word_q[23:0], up_c};
		end
	end

	// ****************************************************************
	// Output events
	// ****************************************************************
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			cmd_valid_o  <= 1'b0;
			cmd_node_o   <= `SPC_N_ROOT;
			cmd_query_o  <= 1'b0;
			cmd_common_o <= 1'b0;
			cmd_code_o   <= 32'h00000000;
			prm_valid_o  <= 1'b0;
			prm_index_o  <= 4'h0;
			prm_kind_o   <= SPC_PK_NUM;
			prm_value_o  <= 16'h0000;
			err_push_o   <= 1'b0;
			err_code_o   <= 16'h0000;
			msg_exec_o   <= 1'b0;
			cal_rest_q   <= 1'b0;
			cal_def_q    <= 1'b0;
		end else begin
			cmd_valid_o <= a_cmd;
			if (a_cmd) begin
				cmd_node_o   <= out_node;
				cmd_query_o  <= query_q;
				cmd_common_o <= common_q;
				cmd_code_o   <= kw_q[31:0];
			end
			prm_valid_o <= a_prm || a_def;
			if (a_prm || a_def) begin
				prm_index_o <= a_def ? 4'h0 : prm_idx_q;
				prm_kind_o  <= a_def ? SPC_PK_DEF : pk;
				prm_value_o <= a_def ? 16'h0000 : pv;
			end
			err_push_o <= a_err;
			if (a_err) err_code_o <= err_c;
			msg_exec_o <= rx_valid_i && is_lf;
			cal_rest_q <= a_cmd && !common_q && !query_q && out_node == `SPC_N_RESTORE;
			cal_def_q  <= a_cmd && !common_q && !query_q && out_node == `SPC_N_DEFAULT;
		end
	end

	// ****************************************************************
	// Calibration store
	// ****************************************************************
	spc_cal_store #(
		.N_COEF    (N_COEF),
		.COEF_W    (COEF_W),
		.P_FACTORY (P_FACTORY)
	) u_cal (
		.sys_clk_i            (sys_clk_i),
		.rst_i                (rst_i),
		.restore_i            (cal_rest_q),
		.default_i            (cal_def_q),
		.boot_done_i          (boot_done_i),
		.boot_csum_ok_i       (boot_csum_ok_i),
		.boot_coef_i          (boot_coef_i),
		.coef_o               (cal_coef_o),
		.flash_fail_message_o (flash_fail_message_o),
		.opt_default_o        (opt_default_o)
	);
endmodule

// >>> tb/spc_cmd_parser_sva.sv
// Port checker for the command parser, bound to its top
`include "spc_consts.svh"
module spc_cmd_parser_sva #(
	parameter int				N_COEF		= 4,
	parameter int				COEF_W		= 16,
	parameter logic [15:0]			P_MIN_VAL	= 16'h0000,
	parameter logic [15:0]			P_MAX_VAL	= 16'h7FFF,
	parameter logic [2*N_COEF*COEF_W-1:0]	P_FACTORY	= '0
) (
	input	wire logic				sys_clk_i,
	input	wire logic				rst_i,
	input	wire logic				rx_valid_i,
	input	wire logic [7:0]			rx_char_i,
	input	wire logic				boot_done_i,
	input	wire logic				boot_csum_ok_i,
	input	wire logic				cmd_valid_o,
	input	wire spc_pkg::spc_node_t		cmd_node_o,
	input	wire logic				cmd_query_o,
	input	wire logic				cmd_common_o,
	input	wire logic				prm_valid_o,
	input	wire spc_pkg::spc_pkind_t		prm_kind_o,
	input	wire logic [15:0]			prm_value_o,
	input	wire logic				msg_exec_o,
	input	wire logic [2*N_COEF*COEF_W-1:0]	cal_coef_o,
	input	wire logic				flash_fail_message_o,
	input	wire logic				opt_default_o
);
	import spc_pkg::*;
	localparam logic [2*N_COEF*COEF_W-1:0] DEFS = {N_COEF{`SPC_CAL_OFFSET_ZERO, `SPC_CAL_GAIN_UNITY}};
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	// Message end, command end, substitutions, calibration and boot fallback
	property p_exec; rx_valid_i && rx_char_i == `SPC_CH_LF |=> msg_exec_o; endproperty
	a_exec: assert property (p_exec) else $error("no exec pulse after line feed");
	property p_cmd; cmd_valid_o |-> $past(rx_valid_i) && $past(rx_char_i) inside {`SPC_CH_SEMI, `SPC_CH_LF}; endproperty
	a_cmd: assert property (p_cmd) else $error("command without separator");
	property p_min; prm_valid_o && prm_kind_o == SPC_PK_MIN |-> prm_value_o == P_MIN_VAL; endproperty
	a_min: assert property (p_min) else $error("bad minimum value");
	property p_max; prm_valid_o && prm_kind_o == SPC_PK_MAX |-> prm_value_o == P_MAX_VAL; endproperty
	a_max: assert property (p_max) else $error("bad maximum value");
	property p_cmn; cmd_valid_o && cmd_common_o |-> cmd_node_o == `SPC_N_ROOT; endproperty
	a_cmn: assert property (p_cmn) else $error("common command not at root");
	property p_def; cmd_valid_o && cmd_node_o == `SPC_N_DEFAULT && !cmd_query_o |=> cal_coef_o == DEFS; endproperty
	a_def: assert property (p_def) else $error("defaults not loaded");
	property p_rest; cmd_valid_o && cmd_node_o == `SPC_N_RESTORE && !cmd_query_o |=> cal_coef_o == P_FACTORY; endproperty
	a_rest: assert property (p_rest) else $error("factory set not loaded");
	property p_boot; boot_done_i && !boot_csum_ok_i |=> flash_fail_message_o && opt_default_o && cal_coef_o == DEFS; endproperty
	a_boot: assert property (p_boot) else $error("no fallback after bad checksum");
endmodule
bind spc_cmd_parser spc_cmd_parser_sva #(.N_COEF(N_COEF), .COEF_W(COEF_W), .P_MIN_VAL(P_MIN_VAL),
	.P_MAX_VAL(P_MAX_VAL), .P_FACTORY(P_FACTORY)) i_spc_cmd_parser_sva (.*);

// >>> tb/spc_host.sv
// Host model that sends command messages one character at a time
module spc_host (
	input	wire logic	sys_clk_i,
	output	logic		rx_valid_o,
	output	logic [7:0]	rx_char_o
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		rx_valid_o = 1'b0;
		rx_char_o = 8'h00;
	end
	// Sends a message with random idle gaps; idle line shows a changed char
	// caller supplies the message terminator; send adds none
	task automatic send(input string s);
		int g;
		for (int i = 0; i < s.len(); i++) begin
			rx_valid_o <= 1'b1;
			rx_char_o <= s[i];
			@(posedge sys_clk_i);
			g = $urandom % 3;
			if (g > 0 || i == s.len() - 1) begin
				rx_valid_o <= 1'b0;
				rx_char_o <= ~s[i];
				repeat (g) @(posedge sys_clk_i);
			end
		end
	endtask
endmodule

// >>> tb/spc_cmd_parser_tb.sv
// Self-checking bench for the command parser
module spc_cmd_parser_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import spc_pkg::*;
	localparam logic [127:0] FAC = {4{16'h0012, 16'h2700}};
	localparam logic [127:0] DEF = {4{16'h0000, 16'h2710}};
	localparam logic [5:0] NC = 6'h3F;
	localparam logic [22:0] NP = 23'h7FFFFF;
	logic		sys_clk_i = 0, rst_i = 1, boot_done_i = 0, boot_csum_ok_i = 0, rx_valid_i;
	logic		cmd_valid_o, cmd_query_o, cmd_common_o, prm_valid_o, err_push_o, msg_exec_o;
	logic		flash_fail_message_o, opt_default_o;
	logic [7:0]	rx_char_i;
	logic [127:0]	boot_coef_i = '0, cal_coef_o;
	logic [3:0]	prm_index_o;
	logic [15:0]	prm_value_o, err_code_o;
	logic [31:0]	cmd_code_o;
	spc_node_t	cmd_node_o;
	spc_pkind_t	prm_kind_o;
	int		miscompares = 0, comparisons = 0;
	logic [5:0]	cq[$];
	logic [22:0]	pq[$];
	logic [15:0]	eq[$];
	spc_cmd_parser #(.P_FACTORY(FAC)) i_spc_cmd_parser (.*);
	spc_host i_spc_host (.sys_clk_i(sys_clk_i), .rx_valid_o(rx_valid_i), .rx_char_o(rx_char_i));
	initial forever #20 sys_clk_i = ~sys_clk_i;
	// Logs reported commands, parameters and errors
	always @(posedge sys_clk_i) begin
		if (cmd_valid_o) cq.push_back({cmd_common_o, cmd_query_o, cmd_node_o});
		if (prm_valid_o) pq.push_back({prm_index_o, prm_kind_o, prm_value_o});
		if (err_push_o) eq.push_back(err_code_o);
	end
	function automatic logic [22:0] pv(input logic [3:0] i, input spc_pkind_t k, input logic [15:0] v);
		return {i, k, v};
	endfunction
	task automatic chk(input logic [127:0] g, input logic [127:0] e);
		comparisons++;
		if (g !== e) begin
			miscompares++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// Sends one message and compares the last command, parameter and error
	task automatic run(input string s, input logic [5:0] c, input logic [22:0] p, input logic [15:0] e);
		cq = {};
		pq = {};
		eq = {};
		i_spc_host.send(s);
		repeat (3) @(posedge sys_clk_i);
		chk(cq.size() ? cq[$] : NC, c);
		chk(pq.size() ? pq[$] : NP, p);
		chk(eq.size() ? eq[$] : 16'h0000, e);
	endtask
	task automatic boot(input logic ok);
		boot_coef_i <= {$urandom, $urandom, $urandom, $urandom};
		boot_csum_ok_i <= ok;
		boot_done_i <= 1'b1;
		@(posedge sys_clk_i);
		boot_done_i <= 1'b0;
		repeat (2) @(posedge sys_clk_i);
	endtask
	task automatic end_of_test();
		$display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge sys_clk_i);
		miscompares++;
		end_of_test();
	end
	initial begin
		int r;
		void'($urandom(67));
		repeat (20) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		@(posedge sys_clk_i);
		run("vOlT 5\n", 6'h04, pv(0, SPC_PK_NUM, 16'h0005), 16'h0000);
		run("VOLTAGE 7\r\n", 6'h04, pv(0, SPC_PK_NUM, 16'h0007), 16'h0000);
		run("VOLTA 1\n", NC, NP, 16'hFF8F);
		run("VOLT 5V\n", NC, NP, 16'hFF7D);
		run("VOLT 1,,3\n", 6'h04, pv(2, SPC_PK_NUM, 16'h0003), 16'h0000);
		run("CURR -12\n", 6'h05, pv(0, SPC_PK_NUM, 16'hFFF4), 16'h0000);
		run("VOLT 1.5\n", NC, NP, 16'hFF9A);
		run("OUTP:STAT ON\n", 6'h0A, pv(0, SPC_PK_WORD, 16'h0000), 16'h0000);
		run("OUTP:STAT 1;STAT 0\n", 6'h0A, pv(0, SPC_PK_NUM, 16'h0000), 16'h0000);
		run("SYST:ERR?;:VOLT?\n", 6'h14, NP, 16'h0000);
		run("VOLT? MAX\n", 6'h14, pv(0, SPC_PK_MAX, 16'h7FFF), 16'h0000);
		run("CURR MIN\n", 6'h05, pv(0, SPC_PK_MIN, 16'h0000), 16'h0000);
		run("VOLT\n", 6'h04, pv(0, SPC_PK_DEF, 16'h0000), 16'h0000);
		run("*RST\n", 6'h20, NP, 16'h0000);
		chk(cmd_code_o, 32'h00525354);
		run("*RSTXX\n", NC, NP, 16'hFF8F);
		run("CALIB\n", NC, NP, 16'hFF8F);
		for (int i = 0; i < 6; i++) begin
			r = $urandom_range(32767);
			run($sformatf("CURR %0d\n", r), 6'h05, pv(0, SPC_PK_NUM, r[15:0]), 16'h0000);
		end
		boot(1'b1);
		chk(cal_coef_o, boot_coef_i);
		run("CAL:DEF\n", 6'h03, NP, 16'h0000);
		chk(cal_coef_o, DEF);
		run("cal:rest\n", 6'h02, NP, 16'h0000);
		chk(cal_coef_o, FAC);
		boot(1'b0);
		chk({cal_coef_o, flash_fail_message_o, opt_default_o}, {DEF, 2'b11});
		end_of_test();
	end
endmodule
